// ### rtl/motor_param_set_select.sv
// selects motor parameter set and ramp times from terminal functions
`timescale 1ns/1ps
// What this block does
// - second-motor input on selects the alternate motor parameter set.
// - second-motor input off returns to the primary motor parameter set.
// - second-motor input changes while running wait until the drive stops.
// - two-stage ramp input on selects second accel and decel times.
// - two-stage ramp input off selects first accel and decel times.
// - two-stage ramp input switches the ramp at once, even mid-ramp.
// - two-stage ramp input only counts when ramp method is terminal code.
// - any of the six terminals may carry either selection function.
module motor_param_set_select
  import param_select_pkg::*;
(
  input wire logic clk_sys, // control clock, 50 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [param_select_pkg::NUM_INPUTS-1:0] terminal_in, // contact levels, high is on
  input wire param_select_pkg::cfg_array_t input_function_cfg, // function per terminal, one to six
  input wire logic drive_running, // high while the drive is not stopped
  input wire logic [param_select_pkg::CFG_W-1:0] second_ramp_method, // second-stage ramp method
  input wire param_select_pkg::ramp_times_s ramp_times_first, // accel_time_first, decel_time_first
  input wire param_select_pkg::ramp_times_s ramp_times_second, // accel_time_second, decel_time_second
  input wire logic [param_select_pkg::MOTOR_W-1:0] motor_primary_params, // primary motor set
  input wire logic [param_select_pkg::MOTOR_W-1:0] motor_alt_params, // alternate motor set
  output logic use_alt_motor, // alternate motor set in force
  output logic [param_select_pkg::MOTOR_W-1:0] active_motor_params, // set seen by the generator
  output logic second_ramp_active, // second ramp times in force
  output param_select_pkg::ramp_times_s active_ramp_times // ramp times seen by the generator
);

  sel_state_s q;
  sel_state_s d;
  logic motor_hit;
  logic ramp_hit;
  logic ramp_req;
  logic next_alt;

  ////////////////////////////////////////////////////////////////////////////////
  // terminal function decoding

  // second motor selection may sit on any terminal
  terminal_function_match u_motor_match (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .terminal_in(terminal_in),
    .function_cfg(input_function_cfg),
    .function_code(FN_SECOND_MOTOR_SELECT),
    .hit(motor_hit)
  );

  // two-stage ramp selection may sit on any terminal as well
  terminal_function_match u_ramp_match (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .terminal_in(terminal_in),
    .function_cfg(input_function_cfg),
    .function_code(FN_TWO_STAGE_RAMP_SELECT),
    .hit(ramp_hit)
  );

  // other ramp methods own the switchover, so the terminal is ignored then
  assign ramp_req = ramp_hit && (second_ramp_method == RAMP_METHOD_TERMINAL);

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  // motor set only moves while stopped; ramp set follows the input every cycle
  always_comb
  begin
    d = q;
    next_alt = 1'b0;
    unique case (q.mstate)
      ST_PRIMARY:
      begin
        if (motor_hit)
        begin
          d.mstate = drive_running ? ST_PEND_ALT : ST_ALT;
        end
      end
      ST_PEND_ALT:
      begin
        // input dropped again before stop: nothing to apply
        if (!motor_hit)
        begin
          d.mstate = ST_PRIMARY;
        end
        else if (!drive_running)
        begin
          d.mstate = ST_ALT;
        end
      end
      ST_ALT:
      begin
        if (!motor_hit)
        begin
          d.mstate = drive_running ? ST_PEND_PRIMARY : ST_PRIMARY;
        end
      end
      ST_PEND_PRIMARY:
      begin
        if (motor_hit)
        begin
          d.mstate = ST_ALT;
        end
        else if (!drive_running)
        begin
          d.mstate = ST_PRIMARY;
        end
      end
    endcase
    // pending states keep the set that was in force when running began
    next_alt = (d.mstate == ST_ALT) || (d.mstate == ST_PEND_PRIMARY);
    d.alt_motor = next_alt;
    d.motor_params = next_alt ? motor_alt_params : motor_primary_params;
    // no wait for the ramp to finish: the rate changes on the next edge
    d.second_ramp = ramp_req;
    d.ramp = ramp_req ? ramp_times_second : ramp_times_first;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  // one register for everything, so the generator never sees a half switch
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      q.mstate <= ST_PRIMARY;
      q.alt_motor <= 1'b0;
      q.second_ramp <= 1'b0;
      q.motor_params <= MOTOR_PARAMS_RESET;
      q.ramp.accel <= RAMP_TIME_RESET;
      q.ramp.decel <= RAMP_TIME_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign use_alt_motor = q.alt_motor;
  assign active_motor_params = q.motor_params;
  assign second_ramp_active = q.second_ramp;
  assign active_ramp_times = q.ramp;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_alt_when_stopped;
    @(posedge clk_sys) disable iff (sys_rst)
    (!drive_running && motor_hit) |=> use_alt_motor;
  endproperty
  a_alt_when_stopped: assert property (p_alt_when_stopped) else $error("alternate set not taken");

  property p_primary_when_stopped;
    @(posedge clk_sys) disable iff (sys_rst)
    (!drive_running && !motor_hit) |=> !use_alt_motor;
  endproperty
  a_primary_when_stopped: assert property (p_primary_when_stopped) else $error("primary set not restored");

  property p_hold_while_running;
    @(posedge clk_sys) disable iff (sys_rst)
    (drive_running && $past(drive_running)) |=> $stable(use_alt_motor);
  endproperty
  a_hold_while_running: assert property (p_hold_while_running) else $error("motor set changed in run");

  property p_pending_applies_at_stop;
    @(posedge clk_sys) disable iff (sys_rst)
    (drive_running && motor_hit && !use_alt_motor) ##1 (!drive_running && motor_hit) |=> use_alt_motor;
  endproperty
  a_pending_applies_at_stop: assert property (p_pending_applies_at_stop) else $error("deferred change lost");

  property p_second_ramp;
    @(posedge clk_sys) disable iff (sys_rst)
    ramp_req |=> second_ramp_active && active_ramp_times == $past(ramp_times_second);
  endproperty
  a_second_ramp: assert property (p_second_ramp) else $error("second ramp times not used");

  property p_first_ramp;
    @(posedge clk_sys) disable iff (sys_rst)
    !ramp_hit |=> !second_ramp_active && active_ramp_times == $past(ramp_times_first);
  endproperty
  a_first_ramp: assert property (p_first_ramp) else $error("first ramp times not used");

  property p_switch_mid_ramp;
    @(posedge clk_sys) disable iff (sys_rst)
    (drive_running && ramp_req && !second_ramp_active) |=> second_ramp_active;
  endproperty
  a_switch_mid_ramp: assert property (p_switch_mid_ramp) else $error("ramp switch waited");

  property p_method_gate;
    @(posedge clk_sys) disable iff (sys_rst)
    (second_ramp_method != RAMP_METHOD_TERMINAL) |=> !second_ramp_active;
  endproperty
  a_method_gate: assert property (p_method_gate) else $error("terminal ramp used with other method");

  property p_set_consistent;
    @(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> active_motor_params == (use_alt_motor ? $past(motor_alt_params) : $past(motor_primary_params));
  endproperty
  a_set_consistent: assert property (p_set_consistent) else $error("motor set and flag disagree");

endmodule

// ### rtl/param_select_pkg.sv
// shared constants and types for the motor parameter set and ramp selection logic
package param_select_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_INPUTS = 6;
  localparam int CFG_W = 8;
  localparam int TIME_W = 16;
  localparam int MOTOR_W = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // input terminal function codes and ramp method codes
  localparam logic [CFG_W-1:0] FN_SECOND_MOTOR_SELECT = 8'h08;
  localparam logic [CFG_W-1:0] FN_TWO_STAGE_RAMP_SELECT = 8'h09;
  localparam logic [CFG_W-1:0] RAMP_METHOD_TERMINAL = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values of the registered selection
  localparam logic [MOTOR_W-1:0] MOTOR_PARAMS_RESET = 32'h0000_0000;
  localparam logic [TIME_W-1:0] RAMP_TIME_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [NUM_INPUTS-1:0][CFG_W-1:0] cfg_array_t;

  typedef struct packed {
    logic [TIME_W-1:0] accel;
    logic [TIME_W-1:0] decel;
  } ramp_times_s;

  // gray codes around the primary -> pending -> alternate -> pending loop
  typedef enum logic [1:0] {
    ST_PRIMARY = 2'b00,
    ST_PEND_ALT = 2'b01,
    ST_ALT = 2'b11,
    ST_PEND_PRIMARY = 2'b10
  } motor_state_e;

  typedef struct packed {
    motor_state_e mstate;
    logic alt_motor;
    logic second_ramp;
    logic [MOTOR_W-1:0] motor_params;
    ramp_times_s ramp;
  } sel_state_s;

endpackage

// ### rtl/terminal_function_match.sv
// finds whether any input terminal assigned a given function is on
`timescale 1ns/1ps
module terminal_function_match
  import param_select_pkg::*;
(
  input wire logic clk_sys, // control clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [param_select_pkg::NUM_INPUTS-1:0] terminal_in, // contact levels, high is on
  input wire param_select_pkg::cfg_array_t function_cfg, // function code per terminal
  input wire logic [param_select_pkg::CFG_W-1:0] function_code, // function looked for
  output logic hit // some terminal with that function is on
);

  logic [NUM_INPUTS-1:0] match;

  ////////////////////////////////////////////////////////////////////////////////
  // every terminal can carry the function, so all six are compared
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_term
      assign match[gi] = terminal_in[gi] && (function_cfg[gi] == function_code);
    end
  endgenerate

  // two terminals on the same function simply or together
  assign hit = |match;

  property p_hit_from_terminal;
    @(posedge clk_sys) disable iff (sys_rst)
    (terminal_in[NUM_INPUTS-1] && function_cfg[NUM_INPUTS-1] == function_code) |-> hit;
  endproperty
  a_hit_from_terminal: assert property (p_hit_from_terminal) else $error("last terminal function ignored");

endmodule

// ### testbench/contact_bank.sv
// model of the switch contacts wired to the six input terminals
`timescale 1ns/1ps
module contact_bank
  import param_select_pkg::*;
#(
  parameter int LAG_NS = 0
)
(
  input wire logic [param_select_pkg::NUM_INPUTS-1:0] close_req, // contacts asked closed
  output logic [param_select_pkg::NUM_INPUTS-1:0] terminal_in // level at the terminals
);
  // clean contacts with an optional travel lag; no bounce, the block has no filter for it
  assign #(LAG_NS) terminal_in = close_req;
endmodule

// ### testbench/motor_param_set_select_test.sv
// self-checking bench for motor set and ramp time selection
`timescale 1ns/1ps
module motor_param_set_select_test;
  import param_select_pkg::*;
  logic clk_sys;
  logic sys_rst;
  logic [NUM_INPUTS-1:0] close_req;
  logic [NUM_INPUTS-1:0] terminal_in;
  cfg_array_t cfg;
  logic running;
  logic [CFG_W-1:0] method;
  ramp_times_s t_first;
  ramp_times_s t_second;
  ramp_times_s t_reset;
  logic [MOTOR_W-1:0] prim_p;
  logic [MOTOR_W-1:0] alt_p;
  logic use_alt_motor;
  logic [MOTOR_W-1:0] active_motor_params;
  logic second_ramp_active;
  ramp_times_s active_ramp_times;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [CFG_W-1:0] bad_methods [3] = '{8'h01, 8'h80, 8'hff};

  ////////////////////////////////////////////////////////////////////////////////
  // clock, partner and design
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  contact_bank #(.LAG_NS(1)) contacts (.close_req(close_req), .terminal_in(terminal_in));

  motor_param_set_select uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .terminal_in(terminal_in),
    .input_function_cfg(cfg), .drive_running(running), .second_ramp_method(method),
    .ramp_times_first(t_first), .ramp_times_second(t_second), .motor_primary_params(prim_p),
    .motor_alt_params(alt_p), .use_alt_motor(use_alt_motor), .active_motor_params(active_motor_params),
    .second_ramp_active(second_ramp_active), .active_ramp_times(active_ramp_times));

  ////////////////////////////////////////////////////////////////////////////////
  // tasks; inputs move 2 ns after the edge so the edge never races them
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic check_motor(input logic exp_alt, input logic [MOTOR_W-1:0] exp_p);
    comparisons++;
    if (use_alt_motor !== exp_alt || active_motor_params !== exp_p)
    begin
      bad_count++;
      $display("CHECK FAILED motor set expected %h/%h seen %h/%h", exp_alt, exp_p, use_alt_motor,
        active_motor_params);
    end
  endtask

  task automatic check_ramp(input logic exp_sec, input ramp_times_s exp_t);
    comparisons++;
    if (second_ramp_active !== exp_sec || active_ramp_times !== exp_t)
    begin
      bad_count++;
      $display("CHECK FAILED ramp times expected %h/%h seen %h/%h", exp_sec, exp_t, second_ramp_active,
        active_ramp_times);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard, the sequence needs well under a hundred cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      bad_count++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    close_req = '0;
    cfg = '0;
    running = 1'b0;
    method = RAMP_METHOD_TERMINAL;
    t_first = '{accel: 16'h0010, decel: 16'h0020};
    t_second = '{accel: 16'h0030, decel: 16'h0040};
    t_reset = '{accel: RAMP_TIME_RESET, decel: RAMP_TIME_RESET};
    prim_p = 32'h1111_1111;
    alt_p = 32'h2222_2222;
    tick(3);
    check_motor(1'b0, MOTOR_PARAMS_RESET);
    check_ramp(1'b0, t_reset);
    sys_rst = 1'b0;
    // each terminal carries each function, its neighbour the other
    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      cfg = '0;
      cfg[i] = FN_SECOND_MOTOR_SELECT;
      cfg[(i + 1) % NUM_INPUTS] = FN_TWO_STAGE_RAMP_SELECT;
      close_req = '0;
      close_req[i] = 1'b1;
      close_req[(i + 1) % NUM_INPUTS] = 1'b1;
      tick(1);
      check_motor(1'b1, alt_p);
      check_ramp(1'b1, t_second);
      close_req = '0;
      tick(1);
      check_motor(1'b0, prim_p);
      check_ramp(1'b0, t_first);
    end
    // motor request while running is held back, ramp switches mid-ramp
    cfg = '0;
    cfg[2] = FN_SECOND_MOTOR_SELECT;
    cfg[3] = FN_TWO_STAGE_RAMP_SELECT;
    running = 1'b1;
    close_req = 6'h04;
    tick(4);
    check_motor(1'b0, prim_p);
    close_req = 6'h0c;
    tick(1);
    check_ramp(1'b1, t_second);
    check_motor(1'b0, prim_p);
    running = 1'b0;
    tick(1);
    check_motor(1'b1, alt_p);
    // a request that reverts before the stop leaves no trace
    running = 1'b1;
    close_req = 6'h08;
    tick(2);
    check_motor(1'b1, alt_p);
    close_req = 6'h0c;
    tick(1);
    running = 1'b0;
    tick(1);
    check_motor(1'b1, alt_p);
    // any method other than the terminal code mutes the ramp terminal
    foreach (bad_methods[k])
    begin
      method = bad_methods[k];
      tick(1);
      check_ramp(1'b0, t_first);
    end
    method = RAMP_METHOD_TERMINAL;
    tick(1);
    check_ramp(1'b1, t_second);
    // second reset with the drive stopped clears both selections
    sys_rst = 1'b1;
    tick(1);
    check_motor(1'b0, MOTOR_PARAMS_RESET);
    check_ramp(1'b0, t_reset);
    // first edge after release loads straight from the inputs, stopped drive
    sys_rst = 1'b0;
    tick(1);
    check_motor(1'b1, alt_p);
    check_ramp(1'b1, t_second);
    // dropping both inputs in run: ramp follows at once, motor set waits
    running = 1'b1;
    close_req = '0;
    tick(1);
    check_motor(1'b1, alt_p);
    check_ramp(1'b0, t_first);
    summarize();
  end
endmodule
